// ===== rtl/conv_pkg.sv
package conv_pkg;
   // special-function register addresses
   localparam logic [7:0] LOW_BYTE_ADDR = 8'hd2;
   localparam logic [7:0] HIGH_BYTE_ADDR = 8'hd3;
   localparam logic [7:0] CONTROL_ADDR = 8'hd4;
   // control field positions
   localparam int ENABLE_POS = 7;
   localparam int SRC_LSB = 3;
   localparam int ALIGN_LSB = 0;
   // reset values and control write mask
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] CONTROL_WMASK = 8'h9f;
   // update sources
   localparam logic [1:0] SRC_WRITE = 2'h0;
   localparam logic [1:0] SRC_TMR3 = 2'h1;
   localparam logic [1:0] SRC_TMR4 = 2'h2;
   localparam logic [1:0] SRC_TMR2 = 2'h3;
endpackage

// ===== rtl/word_align.sv
`timescale 1ns/1ps
// places the 12-bit word from the two data bytes per alignment code
module word_align
   import conv_pkg::*;
(
   // data bytes and format
   input wire logic [7:0] high_byte,
   input wire logic [7:0] low_byte,
   input wire logic [2:0] word_alignment_select,
   // assembled word
   output logic [11:0] word
);
   // bits outside the chosen field are dropped
   always_comb begin
      if (word_alignment_select[2]) begin
         word = {high_byte, low_byte[7:4]}; // RQ11 RQ12
      end else begin
         unique case (word_alignment_select[1:0])
            2'h0: word = {high_byte[3:0], low_byte}; // RQ7
            2'h1: word = {high_byte[4:0], low_byte[7:1]}; // RQ8
            2'h2: word = {high_byte[5:0], low_byte[7:2]}; // RQ9
            2'h3: word = {high_byte[6:0], low_byte[7:3]}; // RQ10
         endcase
      end
   end
endmodule

// ===== rtl/dac_update_and_format_ctrl.sv
`timescale 1ns/1ps
// What this block does
// RQ1: enable bit low shuts converter down and disables output; high runs it.
// RQ2: control bits six and five read zero; writes to them ignored.
// RQ3: source 00 latches the assembled word on each high-byte write.
// RQ4: sources 01,10,11 latch on timer 3, timer 4, timer 2 overflow.
// RQ5: in immediate mode a low-byte write waits for a high-byte write.
// RQ6: in timer modes both bytes wait, then latch together on overflow.
// RQ7: format 000: word is high[3:0] then all of low byte.
// RQ8: format 001: word is high[4:0] then low[7:1].
// RQ9: format 010: word is high[5:0] then low[7:2].
// RQ10: format 011: word is high[6:0] then low[7:3].
// RQ11: format 1xx: word is whole high byte then low[7:4].
// RQ12: unused data bits ignored for the word but read back as written.
module dac_update_and_format_ctrl
   import conv_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // timer overflow pulses
   input wire logic tmr2_ovf,
   input wire logic tmr3_ovf,
   input wire logic tmr4_ovf,
   // converter core
   output logic [11:0] conv_latch,
   output logic conv_enable,
   output logic conv_out_enable,
   output logic conv_load
);
   logic [7:0] second_converter_low_byte_r;
   logic [7:0] second_converter_high_byte_r;
   logic [7:0] second_converter_control_r;
   logic [1:0] update_source_select;
   logic [2:0] word_alignment_select;
   logic [11:0] word;
   logic high_wr;
   logic timer_hit;
   logic high_load_r;

   assign update_source_select =
      second_converter_control_r[SRC_LSB +: 2];
   assign word_alignment_select =
      second_converter_control_r[ALIGN_LSB +: 3];
   assign high_wr = sfr_wr && (sfr_addr == HIGH_BYTE_ADDR);

   ////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         second_converter_low_byte_r <= DATA_RESET;
         second_converter_high_byte_r <= DATA_RESET;
      end else if (sfr_wr) begin
         if (sfr_addr == LOW_BYTE_ADDR) begin
            second_converter_low_byte_r <= sfr_wdata; // RQ5 RQ12
         end
         if (sfr_addr == HIGH_BYTE_ADDR) begin
            second_converter_high_byte_r <= sfr_wdata; // RQ12
         end
      end
   end

   // control register, unused bits kept at zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         second_converter_control_r <= CONTROL_RESET;
      end else if (sfr_wr && sfr_addr == CONTROL_ADDR) begin
         second_converter_control_r <= sfr_wdata & CONTROL_WMASK; // RQ2
      end
   end

   // read mux, registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            LOW_BYTE_ADDR: sfr_rdata <= second_converter_low_byte_r;
            HIGH_BYTE_ADDR: sfr_rdata <= second_converter_high_byte_r;
            CONTROL_ADDR: sfr_rdata <= second_converter_control_r; // RQ2
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // word assembly from the held bytes
   word_align u_align (
      .high_byte(second_converter_high_byte_r),
      .low_byte(second_converter_low_byte_r),
      .word_alignment_select(word_alignment_select),
      .word(word)
   );

   // update trigger selection
   always_comb begin
      unique case (update_source_select)
         SRC_WRITE: timer_hit = 1'b0;
         SRC_TMR3: timer_hit = tmr3_ovf; // RQ4
         SRC_TMR4: timer_hit = tmr4_ovf; // RQ4
         SRC_TMR2: timer_hit = tmr2_ovf; // RQ4
      endcase
   end

   // high-byte write is seen one cycle later once the byte is stored
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_load_r <= 1'b0;
      end else begin
         high_load_r <= high_wr && (update_source_select == SRC_WRITE); // RQ3
      end
   end

   // input latch: immediate on stored high write, or on timer overflow
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_latch <= 12'h000;
         conv_load <= 1'b0;
      end else begin
         conv_load <= high_load_r || timer_hit;
         if (high_load_r || timer_hit) begin
            conv_latch <= word; // RQ3 RQ5 RQ6
         end
      end
   end

   // enable drives power and output pin
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_enable <= 1'b0;
         conv_out_enable <= 1'b0;
      end else begin
         conv_enable <= second_converter_control_r[ENABLE_POS]; // RQ1
         conv_out_enable <= second_converter_control_r[ENABLE_POS]; // RQ1
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks: register port stores and returns what the rules say
   unused_read_a: assert property (@(posedge sys_clk) // RQ2
      disable iff (!rst_n)
      sfr_rd && sfr_addr == CONTROL_ADDR |=> sfr_rdata[6:5] == 2'h0)
      else $error("unused control bits read nonzero");
   control_store_a: assert property (@(posedge sys_clk) // RQ2
      disable iff (!rst_n)
      sfr_wr && sfr_addr == CONTROL_ADDR |=>
      second_converter_control_r[6:5] == 2'h0 &&
      second_converter_control_r[7] == $past(sfr_wdata[7]) &&
      second_converter_control_r[4:0] == $past(sfr_wdata[4:0]))
      else $error("control write stored wrong bits");
   low_store_a: assert property (@(posedge sys_clk) // RQ12
      disable iff (!rst_n)
      sfr_wr && sfr_addr == LOW_BYTE_ADDR |=>
      second_converter_low_byte_r == $past(sfr_wdata))
      else $error("low byte not stored as written");
   high_readback_a: assert property (@(posedge sys_clk) // RQ12
      disable iff (!rst_n)
      sfr_rd && sfr_addr == HIGH_BYTE_ADDR |=>
      sfr_rdata == $past(second_converter_high_byte_r))
      else $error("high byte read back wrong");
   // checks: power and pin follow the enable bit
   enable_follow_a: assert property (@(posedge sys_clk) // RQ1
      disable iff (!rst_n)
      ##1 conv_enable == $past(second_converter_control_r[ENABLE_POS]))
      else $error("converter enable not following control");
   pin_follow_a: assert property (@(posedge sys_clk) // RQ1
      disable iff (!rst_n)
      ##1 conv_out_enable == $past(second_converter_control_r[ENABLE_POS]))
      else $error("output pin enable not following control");
   // checks: when the input latch may and may not change
   immediate_load_a: assert property (@(posedge sys_clk) // RQ3
      disable iff (!rst_n)
      high_wr && update_source_select == SRC_WRITE |=>
      ##1 conv_load && conv_latch == $past(word))
      else $error("high write did not load converter");
   low_held_a: assert property (@(posedge sys_clk) // RQ5
      disable iff (!rst_n)
      sfr_wr && sfr_addr == LOW_BYTE_ADDR && !timer_hit && !high_load_r
      |=> $stable(conv_latch))
      else $error("low write changed converter output");
   high_held_a: assert property (@(posedge sys_clk) // RQ6
      disable iff (!rst_n)
      high_wr && update_source_select != SRC_WRITE && !timer_hit
      |=> $stable(conv_latch))
      else $error("timer mode high write changed output");
   timer_load_a: assert property (@(posedge sys_clk) // RQ4
      disable iff (!rst_n)
      update_source_select == SRC_TMR3 && tmr3_ovf
      |=> conv_load && conv_latch == $past(word))
      else $error("timer 3 overflow did not load word");
   timer4_load_a: assert property (@(posedge sys_clk) // RQ4
      disable iff (!rst_n)
      update_source_select == SRC_TMR4 && tmr4_ovf
      |=> conv_load && conv_latch == $past(word))
      else $error("timer 4 overflow did not load word");
   timer2_load_a: assert property (@(posedge sys_clk) // RQ4
      disable iff (!rst_n)
      update_source_select == SRC_TMR2 && tmr2_ovf
      |=> conv_load && conv_latch == $past(word))
      else $error("timer 2 overflow did not load word");
   timer_hold_a: assert property (@(posedge sys_clk) // RQ6
      disable iff (!rst_n)
      update_source_select != SRC_WRITE && !timer_hit
      |=> !conv_load)
      else $error("timer mode loaded without overflow");
   // checks: word placement for each alignment code
   format_wide_a: assert property (@(posedge sys_clk) // RQ11
      disable iff (!rst_n)
      word_alignment_select[2] |-> word ==
      {second_converter_high_byte_r, second_converter_low_byte_r[7:4]})
      else $error("format 1xx word wrong");
   format_nib_a: assert property (@(posedge sys_clk) // RQ7
      disable iff (!rst_n)
      word_alignment_select == 3'h0 |-> word ==
      {second_converter_high_byte_r[3:0], second_converter_low_byte_r})
      else $error("format 000 word wrong");
   format_five_a: assert property (@(posedge sys_clk) // RQ8
      disable iff (!rst_n)
      word_alignment_select == 3'h1 |-> word ==
      {second_converter_high_byte_r[4:0], second_converter_low_byte_r[7:1]})
      else $error("format 001 word wrong");
   format_six_a: assert property (@(posedge sys_clk) // RQ9
      disable iff (!rst_n)
      word_alignment_select == 3'h2 |-> word ==
      {second_converter_high_byte_r[5:0], second_converter_low_byte_r[7:2]})
      else $error("format 010 word wrong");
   format_seven_a: assert property (@(posedge sys_clk) // RQ10
      disable iff (!rst_n)
      word_alignment_select == 3'h3 |-> word ==
      {second_converter_high_byte_r[6:0], second_converter_low_byte_r[7:3]})
      else $error("format 011 word wrong");
endmodule

// ===== bench/tmr_model.sv
`timescale 1ns/1ps
// timer block model: one-cycle overflow pulse of the requested timer
module tmr_model (
   // clock and request
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [1:0] sel,
   // overflow pulses
   output logic tmr2_ovf,
   output logic tmr3_ovf,
   output logic tmr4_ovf
);
   // each pulse is go registered one clock later, lasting as many clocks as go is held
   always_ff @(posedge sys_clk) begin
      tmr3_ovf <= go && (sel == 2'h1);
      tmr4_ovf <= go && (sel == 2'h2);
      tmr2_ovf <= go && (sel == 2'h3);
   end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import conv_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic go = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, h, l;
   logic tmr2_ovf, tmr3_ovf, tmr4_ovf, conv_enable, conv_out_enable;
   logic conv_load;
   logic [11:0] conv_latch, w = 12'h000;
   logic [11:0] loads = 12'h000, loads_want = 12'h000;
   int errors = 0, checks_done = 0;
   always #4 sys_clk = ~sys_clk;
   // count load pulses at the edge where each one stands
   always @(posedge sys_clk) begin
      if (conv_load) loads <= loads + 12'h001;
   end
   dac_update_and_format_ctrl i_dac_update_and_format_ctrl (.sys_clk,
      .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
      .tmr2_ovf, .tmr3_ovf, .tmr4_ovf, .conv_latch, .conv_enable,
      .conv_out_enable, .conv_load);
   tmr_model i_tmr_model (.sys_clk, .go, .sel, .tmr2_ovf, .tmr3_ovf,
      .tmr4_ovf);
   ////////////////////////////////////////////////////////////////////////
   // compare and count
   task chk(input logic [11:0] seen, input logic [11:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // register write, then wait until the converter latch may follow
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   // register read, data registered one cycle later
   task rdc(input logic [7:0] a, input logic [7:0] want);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({4'h0, sfr_rdata}, {4'h0, want});
   endtask
   // one overflow of the chosen timer
   task tick(input logic [1:0] s);
      @(posedge sys_clk);
      go <= 1'b1;
      sel <= s;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task end_sim;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdc(CONTROL_ADDR, 8'h00);
      chk({10'h000, conv_enable, conv_out_enable}, 12'h000);
      wr(CONTROL_ADDR, 8'hff);
      rdc(CONTROL_ADDR, 8'h9f);
      chk({10'h000, conv_enable, conv_out_enable}, 12'h003);
      $display("test reset and control done");
      // every alignment code, immediate update, one load per high write
      for (int f = 0; f < 8; f++) begin
         wr(CONTROL_ADDR, 8'h80 | 8'(f));
         l = 8'hb7 ^ 8'(f);
         h = 8'h5e + 8'(f);
         wr(LOW_BYTE_ADDR, l);
         chk(conv_latch, w);
         chk(loads, loads_want);
         wr(HIGH_BYTE_ADDR, h);
         w = 12'({h, l} >> ((f < 4) ? f : 4));
         loads_want = loads_want + 12'h001;
         chk(conv_latch, w);
         chk(loads, loads_want);
         rdc(HIGH_BYTE_ADDR, h);
         rdc(LOW_BYTE_ADDR, l);
      end
      $display("test alignment done");
      // each timer source, other timers ignored
      for (int m = 1; m < 4; m++) begin
         wr(CONTROL_ADDR, 8'h84 | 8'(m << 3));
         l = 8'h3c + 8'(m);
         h = 8'h90 ^ 8'(m);
         wr(LOW_BYTE_ADDR, l);
         wr(HIGH_BYTE_ADDR, h);
         chk(conv_latch, w);
         chk(loads, loads_want);
         for (int t = 1; t < 4; t++) if (t != m) tick(2'(t));
         chk(conv_latch, w);
         chk(loads, loads_want);
         tick(2'(m));
         w = {h, l[7:4]};
         loads_want = loads_want + 12'h001;
         chk(conv_latch, w);
         chk(loads, loads_want);
      end
      $display("test timer update done");
      // reset in mid-run while enabled in a timer mode
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdc(CONTROL_ADDR, CONTROL_RESET);
      rdc(LOW_BYTE_ADDR, DATA_RESET);
      rdc(HIGH_BYTE_ADDR, DATA_RESET);
      chk({10'h000, conv_enable, conv_out_enable}, 12'h000);
      $display("test mid-run reset done");
      // power up, then shut down again
      wr(CONTROL_ADDR, 8'h80);
      chk({10'h000, conv_enable, conv_out_enable}, 12'h003);
      wr(CONTROL_ADDR, 8'h00);
      chk({10'h000, conv_enable, conv_out_enable}, 12'h000);
      $display("test shutdown done");
      end_sim();
   end
endmodule
